// file: bench/line_feed_checker.sv
// assertion checker for the line-feed voltage register group
`timescale 1ns/10ps
`include "line_feed_defines.svh"
module line_feed_checker (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic clk_en,
    // register port and line side
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic reverse_feed,
    input wire logic [8*`PROBE_COUNT-1:0] probe_power_all,
    input wire line_feed_pkg::line_ctl_type line_ctl
);
    import line_feed_pkg::*;
    default clocking @(posedge clk_sys); endclocking
    // frozen clock enable holds state, so nothing is judged then
    default disable iff (!rstn || !clk_en);
    // -------------------------------------------------------------------------
    // sequences
    // -------------------------------------------------------------------------
    sequence fwd_s; !reverse_feed [*3]; endsequence
    sequence rev_s; reverse_feed [*3]; endsequence
    sequence quiet_rd_s;
        (!reg_wr && $stable(probe_power_all)) [*4] ##0
            (reg_rd && reg_addr == 8'h4D && line_ctl.probe_valid);
    endsequence
    AST_ONHOOK_RSV: assert property (reg_rd && reg_addr == 8'h48 |=> !reg_rdata[7])
        else $error("onhook reserved bit set");
    AST_LEVEL_RSV: assert property (reg_rd && reg_addr inside {[8'h49:8'h4B]} |=>
        reg_rdata[7:6] == 2'b00) else $error("level reserved bits set");
    AST_PTR_RSV: assert property (reg_rd && reg_addr == 8'h4C |=> reg_rdata[7:3] == 5'h00)
        else $error("pointer reserved bits set");
    AST_POLARITY: assert property (reg_wr && reg_addr == 8'h48 |=> ##1
        line_ctl.idle_polarity_sel == $past(reg_wdata[6], 2)) else $error("polarity wrong");
    AST_FWD_RING: assert property (fwd_s |-> line_ctl.ring_level == 6'h00)
        else $error("ring driven in forward");
    AST_REV_TIP: assert property (rev_s |-> line_ctl.tip_level == 6'h00)
        else $error("tip driven in reverse");
    AST_VALID: assert property (
        line_ctl.probe_valid == (line_ctl.power_probe_pointer <= 3'h5))
        else $error("probe valid wrong");
    AST_RESULT: assert property (quiet_rd_s |=>
        reg_rdata == $past(probe_power_all[8*line_ctl.power_probe_pointer +: 8]))
        else $error("probe result wrong");
endmodule
bind line_feed_voltage_config_regs line_feed_checker u_chk (.clk_sys(clk_sys), .rstn(rstn),
    .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reverse_feed(reverse_feed),
    .probe_power_all(probe_power_all), .line_ctl(line_ctl));

// file: bench/line_feed_voltage_config_regs_tb_top.sv
// self-checking bench for the line-feed voltage register group
`timescale 1ns/10ps
module line_feed_voltage_config_regs_tb_top;
    import line_feed_pkg::*;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic clk_en = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic reverse_feed = 1'b0;
    logic [5:0] auto_level = 6'h0B;
    logic [47:0] probes = 48'h665544332211;
    logic [7:0] reg_rdata;
    line_ctl_type line_ctl;
    logic [7:0] addrs [5] = '{8'h48, 8'h49, 8'h4A, 8'h4B, 8'h4C};
    int n_errors = 0;
    int tests_run = 0;
    int cycles = 0;
    line_feed_voltage_config_regs u_dut (.clk_sys(clk_sys), .rstn(rstn), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .reverse_feed(reverse_feed), .auto_differential_level(auto_level),
        .probe_power_all(probes), .line_ctl(line_ctl));
    // -------------------------------------------------------------------------
    // bus tasks
    // -------------------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask
    task automatic settle;
        repeat (3) @(posedge clk_sys);
        #1;
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // -------------------------------------------------------------------------
    // scenarios
    // -------------------------------------------------------------------------
    task automatic t_reset_and_mask;
        logic [7:0] rst_val [5] = '{8'h20, 8'h02, 8'h32, 8'h10, 8'h00};
        logic [7:0] mask [5] = '{8'h7F, 8'h3F, 8'h3F, 8'h3F, 8'h07};
        for (int i = 0; i < 5; i++) begin
            rd(addrs[i], rst_val[i]);
            wr(addrs[i], 8'hFF);
            rd(addrs[i], mask[i]);
        end
        wr(8'h50, 8'hA5);
        rd(8'h50, 8'h00);
    endtask
    task automatic t_polarity_manual;
        wr(8'h48, 8'h55);
        wr(8'h4E, 8'hFF);
        rd(8'h4E, 8'h01);
        settle;
        chk({7'h00, line_ctl.idle_polarity_sel}, 8'h01);
        chk({7'h00, line_ctl.manual_differential_ctl}, 8'h01);
        chk({2'b00, line_ctl.differential_level}, 8'h15);
        wr(8'h4E, 8'h00);
        settle;
        chk({7'h00, line_ctl.manual_differential_ctl}, 8'h00);
        chk({2'b00, line_ctl.differential_level}, {2'b00, auto_level});
    endtask
    task automatic t_battery;
        wr(8'h4B, 8'h10);
        wr(8'h4A, 8'h32);
        settle;
        chk({2'b00, line_ctl.high_supply_target}, 8'h32);
        chk({2'b00, line_ctl.low_supply_target}, 8'h10);
    endtask
    task automatic t_freeze_and_reset;
        @(posedge clk_sys);
        clk_en <= 1'b0;
        wr(8'h48, 8'h00);
        settle;
        chk({7'h00, line_ctl.idle_polarity_sel}, 8'h01);
        @(posedge clk_sys);
        clk_en <= 1'b1;
        rd(8'h48, 8'h55);
        @(posedge clk_sys);
        rstn <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rstn <= 1'b1;
        rd(8'h48, 8'h20);
        rd(8'h4C, 8'h00);
        settle;
        chk({7'h00, line_ctl.probe_valid}, 8'h01);
    endtask
    task automatic t_feed;
        wr(8'h49, 8'h2A);
        settle;
        chk({2'b00, line_ctl.tip_level}, 8'h2A);
        chk({2'b00, line_ctl.ring_level}, 8'h00);
        @(posedge clk_sys);
        reverse_feed <= 1'b1;
        settle;
        chk({2'b00, line_ctl.ring_level}, 8'h2A);
        chk({2'b00, line_ctl.tip_level}, 8'h00);
    endtask
    task automatic t_probe;
        for (int p = 0; p < 8; p++) begin
            wr(8'h4C, 8'(p));
            settle;
            chk({7'h00, line_ctl.probe_valid}, 8'(p < 6));
            chk({5'h00, line_ctl.power_probe_pointer}, 8'(p));
            rd(8'h4D, (p < 6) ? 8'((p + 1) * 17) : 8'h00);
        end
    endtask
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 2000) begin
            n_errors++;
            report_and_stop();
        end
    end
    initial begin
        repeat (10) @(posedge clk_sys);
        rstn <= 1'b1;
        t_reset_and_mask();
        t_polarity_manual();
        t_feed();
        t_battery();
        t_probe();
        t_freeze_and_reset();
        report_and_stop();
    end
endmodule

// file: hw/line_feed_defines.svh
// offsets, field positions, reset values for the line-feed voltage registers
`ifndef LINE_FEED_DEFINES_SVH
`define LINE_FEED_DEFINES_SVH

`define ONHOOK_LINE_VOLTAGE_ADDR 8'h48
`define COMMON_MODE_VOLTAGE_ADDR 8'h49
`define HIGH_BATTERY_VOLTAGE_ADDR 8'h4A
`define LOW_BATTERY_VOLTAGE_ADDR 8'h4B
`define POWER_PROBE_SELECT_ADDR 8'h4C
`define POWER_PROBE_RESULT_ADDR 8'h4D
`define LINE_CONTROL_ADDR 8'h4E

`define ONHOOK_LINE_VOLTAGE_RESET 8'h20
`define COMMON_MODE_VOLTAGE_RESET 8'h02
`define HIGH_BATTERY_VOLTAGE_RESET 8'h32
`define LOW_BATTERY_VOLTAGE_RESET 8'h10
`define POWER_PROBE_SELECT_RESET 8'h00
`define LINE_CONTROL_RESET 8'h00

`define IDLE_POLARITY_BIT 6
`define LEVEL_MASK 8'h3F
`define ONHOOK_MASK 8'h7F
`define POINTER_MASK 8'h07
`define CONTROL_MASK 8'h01
`define MANUAL_DIFF_BIT 0

`define PROBE_COUNT 6
`define PROBE_LAST 3'h5

`endif

// file: hw/line_feed_pkg.sv
// types for the line-feed voltage register group
package line_feed_pkg;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } bus_req_type;

    typedef struct packed {
        logic idle_polarity_sel;
        logic [5:0] differential_level;
        logic manual_differential_ctl;
        logic [5:0] tip_level;
        logic [5:0] ring_level;
        logic [5:0] high_supply_target;
        logic [5:0] low_supply_target;
        logic [2:0] power_probe_pointer;
        logic probe_valid;
    } line_ctl_type;

    typedef struct packed {
        logic [7:0] onhook;
        logic [7:0] common_mode;
        logic [7:0] high_battery;
        logic [7:0] low_battery;
        logic [7:0] probe_select;
        logic [7:0] control;
        logic [7:0] probe_result;
        logic [7:0] rdata;
        line_ctl_type ctl;
    } state_type;

endpackage

// file: hw/line_feed_voltage_config_regs.sv
// register group holding line-feed voltage targets and the power probe pointer
`timescale 1ns/10ps
`include "line_feed_defines.svh"

// ----------------------------------------------------------------------------
// Notes on behaviour
// [RQ1] on-hook bit 6 picks idle polarity: 0 positive, 1 negative TIP minus RING
// [RQ2] six-bit open-circuit code, 1.5 V per step, 0 to 94.5 V
// [RQ3] on-hook register reads 0x20 after reset, 48 V positive
// [RQ4] common-mode code drives TIP in forward states, RING in reverse states
// [RQ5] common-mode code 0 to -94.5 V in 1.5 V steps, default -3 V
// [RQ6] high battery code 0 to -94.5 V, resets to 0x32, -75 V
// [RQ7] low battery code 0 to -94.5 V, default -24 V
// [RQ8] software keeps high battery magnitude at or above low battery
// [RQ9] battery-selection variant: software matches low code to external rail
// [RQ10] three-bit pointer codes 0 to 5 pick transistors one to six; 6, 7 undefined
// [RQ11] result register reports the selected transistor; pointer resets to zero
// [RQ12] manual differential bit forces line voltage to follow open-circuit code
// [RQ13] result scale 30.4 mW per step for transistors one, two, five, six
// [RQ14] reserved bits read zero, writes to them have no effect
// ----------------------------------------------------------------------------

module line_feed_voltage_config_regs (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic clk_en,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // line state from the feed controller
    input wire logic reverse_feed,
    input wire logic [5:0] auto_differential_level,
    // per-transistor power readings from the monitor, one byte each
    input wire logic [8*`PROBE_COUNT-1:0] probe_power_all,
    // line-feed control outputs
    output line_feed_pkg::line_ctl_type line_ctl
);
    import line_feed_pkg::*;

    state_type state;
    state_type next_state;

    // ------------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------------
    function automatic logic [7:0] pick_probe(input logic [8*`PROBE_COUNT-1:0] all,
                                              input logic [2:0] ptr);
        logic [7:0] result;
        result = 8'h00;
        if (ptr <= `PROBE_LAST) begin
            result = all[8*ptr +: 8];
        end
        return result;
    endfunction

    // the feed's two sides are both sampled once per cycle, so no extra stage is
    // needed: both inputs come from logic on clk_sys
    // ------------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------------
    always_comb begin
        next_state = state;
        if (reg_wr) begin
            unique case (reg_addr)
                `ONHOOK_LINE_VOLTAGE_ADDR: begin
                    next_state.onhook = reg_wdata & `ONHOOK_MASK; // RQ14
                end
                `COMMON_MODE_VOLTAGE_ADDR: begin
                    next_state.common_mode = reg_wdata & `LEVEL_MASK; // RQ14
                end
                `HIGH_BATTERY_VOLTAGE_ADDR: begin
                    next_state.high_battery = reg_wdata & `LEVEL_MASK; // RQ14
                end
                `LOW_BATTERY_VOLTAGE_ADDR: begin
                    next_state.low_battery = reg_wdata & `LEVEL_MASK; // RQ14
                end
                `POWER_PROBE_SELECT_ADDR: begin
                    next_state.probe_select = reg_wdata & `POINTER_MASK; // RQ14
                end
                `LINE_CONTROL_ADDR: begin
                    next_state.control = reg_wdata & `CONTROL_MASK; // RQ14
                end
                default: begin
                end
            endcase
        end

        // result follows the pointer as it stands, refreshed every cycle
        next_state.probe_result = pick_probe(probe_power_all, state.probe_select[2:0]); // RQ11

        next_state.rdata = 8'h00;
        if (reg_rd) begin
            unique case (reg_addr)
                `ONHOOK_LINE_VOLTAGE_ADDR: next_state.rdata = state.onhook;
                `COMMON_MODE_VOLTAGE_ADDR: next_state.rdata = state.common_mode;
                `HIGH_BATTERY_VOLTAGE_ADDR: next_state.rdata = state.high_battery;
                `LOW_BATTERY_VOLTAGE_ADDR: next_state.rdata = state.low_battery;
                `POWER_PROBE_SELECT_ADDR: next_state.rdata = state.probe_select;
                `POWER_PROBE_RESULT_ADDR: next_state.rdata = state.probe_result; // RQ11 RQ13
                `LINE_CONTROL_ADDR: next_state.rdata = state.control;
                default: next_state.rdata = 8'h00;
            endcase
        end

        // outputs are built from the registered copies, so they lag a write by two cycles
        next_state.ctl.idle_polarity_sel = state.onhook[`IDLE_POLARITY_BIT]; // RQ1
        next_state.ctl.manual_differential_ctl = state.control[`MANUAL_DIFF_BIT];
        if (state.control[`MANUAL_DIFF_BIT]) begin
            next_state.ctl.differential_level = state.onhook[5:0]; // RQ12 RQ2
        end else begin
            next_state.ctl.differential_level = auto_differential_level;
        end
        // the idle side not carrying the common-mode level is left at code zero
        if (reverse_feed) begin
            next_state.ctl.tip_level = 6'h00;
            next_state.ctl.ring_level = state.common_mode[5:0]; // RQ4 RQ5
        end else begin
            next_state.ctl.tip_level = state.common_mode[5:0]; // RQ4 RQ5
            next_state.ctl.ring_level = 6'h00;
        end
        // ordering of the two targets is software's duty; not clamped here
        next_state.ctl.high_supply_target = state.high_battery[5:0]; // RQ6 RQ8
        next_state.ctl.low_supply_target = state.low_battery[5:0]; // RQ7 RQ9
        next_state.ctl.power_probe_pointer = state.probe_select[2:0]; // RQ10
        next_state.ctl.probe_valid = (state.probe_select[2:0] <= `PROBE_LAST); // RQ10
    end

    // ------------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            state <= '0;
            state.onhook <= `ONHOOK_LINE_VOLTAGE_RESET; // RQ3
            state.common_mode <= `COMMON_MODE_VOLTAGE_RESET; // RQ5
            state.high_battery <= `HIGH_BATTERY_VOLTAGE_RESET; // RQ6
            state.low_battery <= `LOW_BATTERY_VOLTAGE_RESET; // RQ7
            state.probe_select <= `POWER_PROBE_SELECT_RESET; // RQ11
            state.control <= `LINE_CONTROL_RESET;
            // pointer resets to the first transistor, so the select is already valid
            state.ctl.probe_valid <= 1'b1; // RQ10 RQ11
        end else if (clk_en) begin
            state <= next_state;
        end
    end

    assign reg_rdata = state.rdata;
    assign line_ctl = state.ctl;

endmodule
